// ==== rtl/ssch_top.sv ====
// Purpose: slow-channel message scheduler, slots 22 to 31
// Assumes: measurement inputs synchronous to pclk
// Notes:   messages queue in a fifo; outputs are registered
//
// Functional notes
// - slots 25, 29 send fault identifier and flags
// - slot 26 sends amplitude bits 16 to 5
// - slot 30 sends programmable device word
// - slots 27, 28, 31 send page four words
// - slots 23, 24 send page three words
// - slot 22 sends excitation current code
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "ssch_consts.svh"
module ssch_top import ssch_pkg::*; (
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // device measurements
   input  wire logic [8:0]  fault_flags,
   input  wire logic [16:0] receiver_coil_voltage,
   input  wire logic [7:0]  excitation_code,
   // message stream
   output logic             msg_valid,
   output logic [7:0]       msg_id,
   output logic [11:0]      msg_payload,
   input  wire logic        msg_ready
);
   // ==========================================================
   // helpers
   function automatic ssch_id_t make_id(input logic [3:0] pfx,
                                        input logic [3:0] idx);
      make_id = {pfx, idx};
   endfunction

   // ==========================================================
   // state
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic        enable_q;
   logic [4:0]  slot_q;
   logic [3:0]  pfx3_q;
   logic [3:0]  pfx4_q;
   logic [3:0]  page3_word3_index;
   logic [3:0]  page3_word4_index;
   logic [3:0]  page4_word1_index;
   logic [3:0]  page4_word2_index;
   logic [3:0]  page4_word3_index;
   logic [11:0] slow_channel_device_word;
   logic [11:0] user_word_q [0:`SSCH_UW_N-1];
   logic        msg_valid_q;
   ssch_msg_s   msg_q;

   ssch_fifo_if #(.W(`SSCH_MSG_W), .LW(`SSCH_LVL_W)) fq ();

   ssch_fifo #(.W(`SSCH_MSG_W), .D(`SSCH_FIFO_D), .LW(`SSCH_LVL_W))
      u_fifo (.clk(pclk), .rst_n(presetn), .ce(ce), .fp(fq.store));

   // ==========================================================
   // apb decode
   wire access_go = psel & penable & ~pready_q;
   wire done      = psel & penable & pready_q;
   wire wr_en     = done & pwrite & ce;
   wire hit_ctrl  = (paddr == `SSCH_OFF_CTRL);
   wire hit_stat  = (paddr == `SSCH_OFF_STAT);
   wire hit_pfx   = (paddr == `SSCH_OFF_PFX);
   wire hit_idx   = (paddr == `SSCH_OFF_IDX);
   wire hit_dev   = (paddr == `SSCH_OFF_DEV);
   wire hit_uw    = (paddr >= `SSCH_OFF_UW0) &&
                    (paddr <= `SSCH_UW_LAST) && (paddr[1:0] == 2'h0);
   wire hit_any   = hit_ctrl | hit_stat | hit_pfx | hit_idx |
                    hit_dev | hit_uw;
   wire [7:0] uw_off = paddr - `SSCH_OFF_UW0;
   wire [2:0] uw_sel = uw_off[4:2];
   wire restart   = wr_en & hit_ctrl & pwdata[`SSCH_CTRL_RST];
   wire [31:0] rd_mux =
      hit_ctrl ? {31'h00000000, enable_q} :
      hit_stat ? {16'h0000, 3'h0, fq.level, 3'h0, slot_q} :
      hit_pfx  ? {24'h000000, pfx4_q, pfx3_q} :
      hit_idx  ? {12'h000, page4_word3_index, page4_word2_index,
                  page4_word1_index, page3_word4_index,
                  page3_word3_index} :
      hit_dev  ? {20'h00000, slow_channel_device_word} :
      hit_uw   ? {20'h00000, user_word_q[uw_sel]} :
                 `SSCH_RST_DATA;

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= `SSCH_RST_DATA;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pready_q  <= access_go;
         pslverr_q <= access_go & ~hit_any;
         if (access_go) begin
            prdata_q <= pwrite ? `SSCH_RST_DATA : rd_mux;
         end
      end
   end

   // ==========================================================
   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q                 <= 1'b0;
         pfx3_q                   <= `SSCH_RST_NIB;
         pfx4_q                   <= `SSCH_RST_NIB;
         page3_word3_index        <= `SSCH_RST_NIB;
         page3_word4_index        <= `SSCH_RST_NIB;
         page4_word1_index        <= `SSCH_RST_NIB;
         page4_word2_index        <= `SSCH_RST_NIB;
         page4_word3_index        <= `SSCH_RST_NIB;
         slow_channel_device_word <= `SSCH_RST_WORD;
         for (int i = 0; i < `SSCH_UW_N; i++) begin
            user_word_q[i] <= `SSCH_RST_WORD;
         end
      end else if (wr_en) begin
         if (hit_ctrl) begin
            enable_q <= pwdata[`SSCH_CTRL_EN];
         end
         if (hit_pfx) begin
            pfx3_q <= pwdata[3:0];
            pfx4_q <= pwdata[7:4];
         end
         if (hit_idx) begin
            page3_word3_index <= pwdata[3:0];
            page3_word4_index <= pwdata[7:4];
            page4_word1_index <= pwdata[11:8];
            page4_word2_index <= pwdata[15:12];
            page4_word3_index <= pwdata[19:16];
         end
         if (hit_dev) begin
            slow_channel_device_word <= pwdata[11:0];
         end
         if (hit_uw) begin
            user_word_q[uw_sel] <= pwdata[11:0];
         end
      end
   end

   // ==========================================================
   // slot content
   // fixed identifiers
   // identifier from page prefix and index
   wire ssch_id_t gen_id =
      (slot_q == `SSCH_SLOT_EXC)   ? `SSCH_ID_EXC :
      (slot_q == `SSCH_SLOT_P3W3)  ? make_id(pfx3_q, page3_word3_index) :
      (slot_q == `SSCH_SLOT_P3W4)  ? make_id(pfx3_q, page3_word4_index) :
      (slot_q == `SSCH_SLOT_FLT_A) ? `SSCH_ID_FAULT :
      (slot_q == `SSCH_SLOT_AMP)   ? `SSCH_ID_AMP :
      (slot_q == `SSCH_SLOT_P4W1)  ? make_id(pfx4_q, page4_word1_index) :
      (slot_q == `SSCH_SLOT_P4W2)  ? make_id(pfx4_q, page4_word2_index) :
      (slot_q == `SSCH_SLOT_FLT_B) ? `SSCH_ID_FAULT :
      (slot_q == `SSCH_SLOT_DEV)   ? `SSCH_ID_DEV :
                                     make_id(pfx4_q, page4_word3_index);

   wire ssch_pl_t gen_pl =
      (slot_q == `SSCH_SLOT_EXC)   ? {4'h0, excitation_code} :
      (slot_q == `SSCH_SLOT_P3W3)  ? user_word_q[0] :
      (slot_q == `SSCH_SLOT_P3W4)  ? user_word_q[1] :
      (slot_q == `SSCH_SLOT_FLT_A) ? {3'h0, fault_flags} :
      (slot_q == `SSCH_SLOT_AMP)   ? receiver_coil_voltage[16:5] :
      (slot_q == `SSCH_SLOT_P4W1)  ? user_word_q[2] :
      (slot_q == `SSCH_SLOT_P4W2)  ? user_word_q[3] :
      (slot_q == `SSCH_SLOT_FLT_B) ? {3'h0, fault_flags} :
      (slot_q == `SSCH_SLOT_DEV)   ? slow_channel_device_word :
                                     user_word_q[4];

   assign fq.wr_valid = enable_q;
   assign fq.wr_data  = {gen_id, gen_pl};
   wire push = fq.wr_valid & fq.wr_ready & ce;

   // flags are sampled when queued, so a full fifo delays freshness
   // slot advance and wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_q <= `SSCH_SLOT_FIRST;
      end else if (restart) begin
         slot_q <= `SSCH_SLOT_FIRST;
      end else if (push) begin
         slot_q <= (slot_q == `SSCH_SLOT_LAST) ? `SSCH_SLOT_FIRST
                                                : slot_q + 5'h01;
      end
   end

   // ==========================================================
   // output stage
   assign fq.rd_ready = ~msg_valid_q | msg_ready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msg_valid_q <= 1'b0;
         msg_q       <= '0;
      end else if (ce && fq.rd_ready) begin
         msg_valid_q <= fq.rd_valid;
         if (fq.rd_valid) begin
            msg_q <= fq.rd_data;
         end
      end
   end

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign msg_valid   = msg_valid_q;
   assign msg_id      = msg_q.id;
   assign msg_payload = msg_q.pl;

   // ==========================================================
   // checks
   a_fault_slot:
   assert property (@(posedge pclk) disable iff (!presetn)
      push && (slot_q == `SSCH_SLOT_FLT_A || slot_q == `SSCH_SLOT_FLT_B)
      |-> fq.wr_data == {`SSCH_ID_FAULT, 3'h0, fault_flags})
      else $error("fault slot message wrong");

   a_amp_slot:
   assert property (@(posedge pclk) disable iff (!presetn)
      push && slot_q == `SSCH_SLOT_AMP
      |-> fq.wr_data == {`SSCH_ID_AMP, receiver_coil_voltage[16:5]})
      else $error("amplitude slot message wrong");

   a_dev_slot:
   assert property (@(posedge pclk) disable iff (!presetn)
      push && slot_q == `SSCH_SLOT_DEV
      |-> fq.wr_data == {`SSCH_ID_DEV, slow_channel_device_word})
      else $error("device word slot message wrong");

   a_page4_id:
   assert property (@(posedge pclk) disable iff (!presetn)
      push && slot_q == `SSCH_SLOT_LAST
      |-> fq.wr_data == {pfx4_q, page4_word3_index, user_word_q[4]})
      else $error("page four slot message wrong");

   a_page3_id:
   assert property (@(posedge pclk) disable iff (!presetn)
      push && slot_q == `SSCH_SLOT_P3W4
      |-> fq.wr_data == {pfx3_q, page3_word4_index, user_word_q[1]})
      else $error("page three slot message wrong");

   a_exc_slot:
   assert property (@(posedge pclk) disable iff (!presetn)
      push && slot_q == `SSCH_SLOT_EXC
      |-> fq.wr_data == {`SSCH_ID_EXC, 4'h0, excitation_code})
      else $error("excitation slot message wrong");

   a_slot_wrap:
   assert property (@(posedge pclk) disable iff (!presetn)
      push && !restart && slot_q == `SSCH_SLOT_LAST
      |=> slot_q == `SSCH_SLOT_FIRST)
      else $error("slot counter did not wrap");

   a_slot_step:
   assert property (@(posedge pclk) disable iff (!presetn)
      push && !restart && slot_q != `SSCH_SLOT_LAST
      |=> slot_q == $past(slot_q) + 5'h01)
      else $error("slot counter did not advance");
endmodule

// ==== shared/ssch_consts.svh ====
// Purpose: named constants of the slow-channel scheduler
// Assumes: included by package and design modules
// Notes:   addresses are APB byte addresses
`ifndef SSCH_CONSTS_SVH
`define SSCH_CONSTS_SVH

// ==========================================================
// message format
`define SSCH_ID_W        8
`define SSCH_PL_W        12
`define SSCH_MSG_W       20
`define SSCH_FIFO_D      16
`define SSCH_LVL_W       5

// ==========================================================
// slot numbers
`define SSCH_SLOT_FIRST  5'h16
`define SSCH_SLOT_EXC    5'h16
`define SSCH_SLOT_P3W3   5'h17
`define SSCH_SLOT_P3W4   5'h18
`define SSCH_SLOT_FLT_A  5'h19
`define SSCH_SLOT_AMP    5'h1A
`define SSCH_SLOT_P4W1   5'h1B
`define SSCH_SLOT_P4W2   5'h1C
`define SSCH_SLOT_FLT_B  5'h1D
`define SSCH_SLOT_DEV    5'h1E
`define SSCH_SLOT_LAST   5'h1F

// ==========================================================
// fixed identifiers
`define SSCH_ID_FAULT    8'h01
`define SSCH_ID_EXC      8'h83
`define SSCH_ID_AMP      8'h85
`define SSCH_ID_DEV      8'h87

// ==========================================================
// register offsets
`define SSCH_OFF_CTRL    8'h00
`define SSCH_OFF_STAT    8'h04
`define SSCH_OFF_PFX     8'h08
`define SSCH_OFF_IDX     8'h0C
`define SSCH_OFF_DEV     8'h10
`define SSCH_OFF_UW0     8'h14
`define SSCH_UW_N        5
`define SSCH_UW_LAST     8'h24

// ==========================================================
// field positions and reset values
`define SSCH_CTRL_EN     0
`define SSCH_CTRL_RST    1
`define SSCH_RST_NIB     4'h0
`define SSCH_RST_WORD    12'h000
`define SSCH_RST_DATA    32'h00000000

`endif

// ==== shared/ssch_pkg.sv ====
// Purpose: types of the slow-channel scheduler
// Assumes: constants header on the include path
// Notes:   message is identifier above payload
`include "ssch_consts.svh"
package ssch_pkg;
   typedef logic [`SSCH_ID_W-1:0] ssch_id_t;
   typedef logic [`SSCH_PL_W-1:0] ssch_pl_t;
   typedef struct packed {
      ssch_id_t id;
      ssch_pl_t pl;
   } ssch_msg_s;
endpackage

// ==== shared/ssch_fifo_if.sv ====
// Purpose: carrier between scheduler core and message fifo
// Assumes: one clock domain
// Notes:   store side is the fifo, user side is the core
`timescale 1ns/1ns
interface ssch_fifo_if #(parameter int W = 20, parameter int LW = 5);
   logic          wr_valid;
   logic          wr_ready;
   logic [W-1:0]  wr_data;
   logic          rd_valid;
   logic          rd_ready;
   logic [W-1:0]  rd_data;
   logic [LW-1:0] level;
   modport store (input wr_valid, wr_data, rd_ready,
                  output wr_ready, rd_valid, rd_data, level);
   modport user  (output wr_valid, wr_data, rd_ready,
                  input wr_ready, rd_valid, rd_data, level);
endinterface

// ==== rtl/ssch_fifo.sv ====
// Purpose: message fifo with valid/ready on both sides
// Assumes: D is a power of two, LW holds D
// Notes:   full drops wr_ready, so the core stalls
`timescale 1ns/1ns
module ssch_fifo #(
   parameter int W  = 20,
   parameter int D  = 16,
   parameter int LW = 5
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // fifo sides
   ssch_fifo_if.store fp
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [0:D-1];
   logic [AW:0]  wp_q;
   logic [AW:0]  rp_q;
   wire  [AW:0]  used = wp_q - rp_q;
   wire          full = (used == (AW+1)'(D));
   wire          empty = (used == '0);
   wire          push = fp.wr_valid & ~full & ce;
   wire          pop = fp.rd_ready & ~empty & ce;

   assign fp.wr_ready = ~full;
   assign fp.rd_valid = ~empty;
   assign fp.rd_data  = mem[rp_q[AW-1:0]];
   assign fp.level    = LW'(used);

   // ==========================================================
   // storage and pointers
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q[AW-1:0]] <= fp.wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule

// ==== verification/ssch_rx_model.sv ====
// Purpose: message consumer standing where the receiver takes messages
// Assumes: one clock, stream handshake valid and ready
// Notes:   hold stalls it outright, slow takes every other cycle
`timescale 1ns/1ns
module ssch_rx_model (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // message stream
   output logic      msg_ready,
   // pace control
   input  wire logic hold,
   input  wire logic slow
);
   // ===========================================================
   // pacing
   logic tick_q;
   // ready flips only right after an edge, as a real sink would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msg_ready <= 1'b0;
         tick_q    <= 1'b0;
      end else begin
         tick_q    <= ~tick_q;
         msg_ready <= !hold && (!slow || tick_q);
      end
   end
endmodule

// ==== verification/sent_slow_channel_scheduler_tb_top.sv ====
// Purpose: self-checking bench of the slow-channel scheduler
// Assumes: apb slave answers with one wait state
// Notes:   inputs held steady so queued messages stay predictable
`timescale 1ns/1ns
`include "ssch_consts.svh"
module sent_slow_channel_scheduler_tb_top;
   // ===========================================================
   // signals
   localparam logic [7:0]  PFX = 8'hB5;
   localparam logic [19:0] IDX = 20'h9C3A7;
   localparam logic [11:0] DEV = 12'hD4E;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, excitation_code, msg_id;
   logic [31:0] pwdata, prdata, rd;
   logic [8:0]  fault_flags;
   logic [16:0] receiver_coil_voltage;
   logic        msg_valid, msg_ready, hold, slow, er;
   logic [11:0] msg_payload;
   logic [11:0] uw [5] = '{12'h123, 12'h456, 12'h789, 12'hABC, 12'hDEF};
   logic [19:0] got [$];
   logic [20:0] m;
   int          fail_count, checks, i, n;

   ssch_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fault_flags(fault_flags), .excitation_code(excitation_code),
      .receiver_coil_voltage(receiver_coil_voltage),
      .msg_valid(msg_valid), .msg_id(msg_id), .msg_payload(msg_payload),
      .msg_ready(msg_ready));
   ssch_rx_model rx (.pclk(pclk), .presetn(presetn), .msg_ready(msg_ready),
      .hold(hold), .slow(slow));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // every accepted message is logged for the in-order compare
   always @(posedge pclk) begin
      if (ce === 1'b1 && msg_valid === 1'b1 && msg_ready === 1'b1) begin
         got.push_back({msg_id, msg_payload});
      end
   end

   // ===========================================================
   // helpers
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic timeout_fail;
      fail_count++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      results();
   endtask

   // bounded wait until the logger holds the wanted message count
   task automatic wait_got(input int want);
      int k;
      k = 0;
      while (got.size() < want && k < 400) begin
         @(posedge pclk);
         k++;
      end
      if (got.size() < want) timeout_fail();
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) timeout_fail();
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [19:0] exp_msg(input int s);
      case (s)
         22: exp_msg = {8'h83, 4'h0, excitation_code};
         23: exp_msg = {PFX[3:0], IDX[3:0], uw[0]};
         24: exp_msg = {PFX[3:0], IDX[7:4], uw[1]};
         25, 29: exp_msg = {8'h01, 3'h0, fault_flags};
         26: exp_msg = {8'h85, receiver_coil_voltage[16:5]};
         27: exp_msg = {PFX[7:4], IDX[11:8], uw[2]};
         28: exp_msg = {PFX[7:4], IDX[15:12], uw[3]};
         30: exp_msg = {8'h87, DEV};
         default: exp_msg = {PFX[7:4], IDX[19:16], uw[4]};
      endcase
   endfunction

   // ===========================================================
   // main sequence
   initial begin
      {psel, penable, pwrite, slow} = 4'h0;
      hold = 1'b1;
      ce = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      fault_flags = 9'h1A5;
      receiver_coil_voltage = 17'h1B3C5;
      excitation_code = 8'h6D;
      fail_count = 0;
      checks = 0;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(msg_valid, 32'h0);
      apb(1'b0, `SSCH_OFF_STAT, 32'h0);
      chk(rd, 32'h00000016);
      apb(1'b0, `SSCH_OFF_PFX, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `SSCH_OFF_PFX, {24'h0, PFX});
      apb(1'b1, `SSCH_OFF_IDX, {12'h0, IDX});
      apb(1'b1, `SSCH_OFF_DEV, {20'h0, DEV});
      for (i = 0; i < 5; i++) apb(1'b1, 8'h14 + 8'(4 * i), {20'h0, uw[i]});
      apb(1'b0, `SSCH_OFF_DEV, 32'h0);
      chk(rd, {20'h0, DEV});
      chk(er, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(er, 32'h1);
      chk(rd, 32'h0);
      // fill the fifo with the receiver stalled
      apb(1'b1, `SSCH_OFF_CTRL, 32'h1);
      n = 0;
      do begin
         apb(1'b0, `SSCH_OFF_STAT, 32'h0);
         n++;
      end while (rd[12:8] !== 5'h10 && n < 40);
      if (rd[12:8] !== 5'h10) timeout_fail();
      chk(rd[12:8], 32'h10);
      chk(msg_valid, 32'h1);
      chk(msg_id, 32'h83);
      hold <= 1'b0;
      slow <= 1'b1;
      wait_got(20);
      // two full turns, wrap included
      for (i = 0; i < 20; i++) begin
         chk(got[i], exp_msg(22 + i % 10));
      end
      // a low enable freezes the stream in mid-flow
      ce <= 1'b0;
      @(posedge pclk);
      m = {msg_valid, msg_id, msg_payload};
      n = got.size();
      repeat (4) @(posedge pclk);
      chk({msg_valid, msg_id, msg_payload}, m);
      chk(got.size(), n);
      ce <= 1'b1;
      // nothing lost or repeated across the freeze
      wait_got(30);
      for (i = 20; i < 30; i++) begin
         chk(got[i], exp_msg(22 + i % 10));
      end
      apb(1'b1, `SSCH_OFF_CTRL, 32'h2);
      apb(1'b0, `SSCH_OFF_STAT, 32'h0);
      chk(rd[4:0], 32'h16);
      apb(1'b0, `SSCH_OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      slow <= 1'b0;
      n = 0;
      while (msg_valid !== 1'b0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      if (msg_valid !== 1'b0) timeout_fail();
      chk(msg_valid, 32'h0);
      apb(1'b0, `SSCH_OFF_STAT, 32'h0);
      chk(rd[12:8], 32'h0);
      results();
   end
endmodule
